// >>> hdl/filt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface filt_if;
  logic req;
  logic ok;
  logic busy;
  modport src (output req, input ok, input busy);
  modport flt (input req, output ok, output busy);
endinterface : filt_if
`default_nettype wire

// >>> hdl/hold_filter.sv
`timescale 1ns/100ps
`default_nettype none
module hold_filter #(
  parameter int unsigned LEN = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request and qualified level
  filt_if.flt f
);
  import rst_pkg::*;
  localparam int unsigned CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LEN_W = CW'(LEN);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire hit = (cnt_r == LEN_W);

  // Any low sample restarts the count, so short pulses never qualify
  assign cnt_nxt = !f.req ? '0 : (hit ? cnt_r : cnt_r + CW'(1));
  assign f.ok = hit;
  assign f.busy = f.req && !hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : hold_filter
`default_nettype wire

// >>> hdl/initial_reset_controller.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module initial_reset_controller #(
  parameter int unsigned FILT_LEN = rst_pkg::FILT_CYC,
  parameter int unsigned LONG_LEN = rst_pkg::LONG_CYC,
  parameter rst_pkg::key_sel_t KEY_SEL_DEF = rst_pkg::KEY_0123,
  parameter logic LONG_DEF = 1'b0
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset sources
  input wire logic osc_running,
  input wire logic reset_pin,
  input wire logic [3:0] key_inputs,
  input wire logic wdt_runaway,
  // Core register next values
  input wire logic [7:0] core_step_nxt,
  input wire logic [3:0] core_page_nxt,
  input wire logic [3:0] core_npp_nxt,
  input wire logic core_irq_flag_nxt,
  input wire logic core_dec_flag_nxt,
  input wire logic [3:0] vec_sel,
  // Reset and core state
  output logic sys_rst,
  output logic cpu_run,
  output logic [7:0] program_step_counter,
  output logic [3:0] program_page_counter,
  output logic [3:0] next_page_pointer,
  output logic irq_flag,
  output logic dec_flag,
  output logic [11:0] fetch_addr,
  output logic [11:0] vector_addr
);
  import rst_pkg::*;

  // Reset release through two flip-flops
  logic rst_ff1_r;
  logic rst_ff2_r;
  wire rst_n = rst_ff2_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_ff1_r <= 1'b0;
      rst_ff2_r <= 1'b0;
    end else begin
      rst_ff1_r <= 1'b1;
      rst_ff2_r <= rst_ff1_r;
    end
  end

  // Input synchronisers; first stage feeds only the second
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  wire [6:0] pins_in = {wdt_runaway, osc_running, reset_pin, key_inputs};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  wire [3:0] key_s = sync2_r[3:0];
  wire pin_s = sync2_r[4];
  wire osc_s = sync2_r[5];
  wire wdt_s = sync2_r[6];

  // Software controls
  key_sel_t key_sel_r;
  logic long_en_r;
  logic [3:0] cause_r;

  // Key combination mask, one bit per key input
  logic [3:0] key_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      if (gi < 2) begin : g_lo
        assign key_mask[gi] = (key_sel_r != KEY_NONE);
      end else begin : g_hi
        assign key_mask[gi] = (key_sel_r >= key_sel_t'(gi));
      end
    end
  endgenerate

  // All selected keys high at once; nothing selected never fires
  wire key_all = (key_sel_r != KEY_NONE) && (&(key_s | ~key_mask));

  filt_if pin_f ();
  filt_if key_f ();
  filt_if long_f ();

  assign pin_f.req = pin_s;
  assign key_f.req = key_all;
  assign long_f.req = key_f.ok && long_en_r;

  hold_filter #(.LEN(FILT_LEN)) u_pin_filt (
    .clk(clk),
    .rst_n(rst_n),
    .f(pin_f.flt)
  );

  hold_filter #(.LEN(FILT_LEN)) u_key_filt (
    .clk(clk),
    .rst_n(rst_n),
    .f(key_f.flt)
  );

  hold_filter #(.LEN(LONG_LEN)) u_long_filt (
    .clk(clk),
    .rst_n(rst_n),
    .f(long_f.flt)
  );

  wire pin_ok = pin_f.ok;
  wire key_ok = long_en_r ? long_f.ok : key_f.ok;
  wire any_src = pin_ok || key_ok || wdt_s;
  wire filt_busy = pin_f.busy || key_f.busy || long_f.busy;

  // Reset sequencer
  rst_state_t state_r;
  rst_state_t state_nxt;
  logic [SW-1:0] stretch_r;
  logic [SW-1:0] stretch_nxt;
  wire stretch_done = (stretch_r == '0);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POR: begin
        if (osc_s) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!osc_s) begin
          state_nxt = ST_POR;
        end else if (!any_src && !filt_busy && stretch_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!osc_s) begin
          state_nxt = ST_POR;
        end else if (any_src) begin
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_POR;
      end
    endcase
  end

  // Short stretch so a one-cycle watchdog pulse still gives a full reset
  assign stretch_nxt = any_src ? SW'(STRETCH_CYC) :
                       (stretch_done ? stretch_r : stretch_r - SW'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_POR;
      stretch_r <= SW'(STRETCH_CYC);
    end else begin
      state_r <= state_nxt;
      stretch_r <= stretch_nxt;
    end
  end

  assign sys_rst = (state_r != ST_RUN);
  assign cpu_run = (state_r == ST_RUN);

  // Core registers held at entry values during reset
  logic [7:0] step_r;
  logic [3:0] page_r;
  logic [3:0] npp_r;
  logic irq_r;
  logic dec_r;
  logic [11:0] vec_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= STEP_RST;
      page_r <= PAGE_RST;
      npp_r <= NEXT_PAGE_RST;
      irq_r <= FLAG_RST;
      dec_r <= FLAG_RST;
    end else if (sys_rst) begin
      step_r <= STEP_RST;
      page_r <= PAGE_RST;
      npp_r <= NEXT_PAGE_RST;
      irq_r <= FLAG_RST;
      dec_r <= FLAG_RST;
    end else begin
      step_r <= core_step_nxt;
      page_r <= core_page_nxt;
      npp_r <= core_npp_nxt;
      irq_r <= core_irq_flag_nxt;
      dec_r <= core_dec_flag_nxt;
    end
  end

  // Vector zero is the reset entry, so it maps to the first vector
  wire [3:0] vec_idx = (vec_sel < VEC_FIRST) ? VEC_FIRST : vec_sel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_r <= {VEC_PAGE, 4'h0, VEC_FIRST};
    end else begin
      vec_r <= {VEC_PAGE, 4'h0, vec_idx};
    end
  end

  assign program_step_counter = step_r;
  assign program_page_counter = page_r;
  assign next_page_pointer = npp_r;
  assign irq_flag = irq_r;
  assign dec_flag = dec_r;
  assign fetch_addr = {page_r, step_r};
  assign vector_addr = vec_r;

  // AXI4-Lite write path; address and data may come in either order
  logic aw_have_r;
  logic w_have_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_have_r && w_have_r && !bvalid_r;
  wire [11:0] wr_addr = {aw_addr_r[11:2], 2'b00};
  wire wr_ctrl = wr_go && (wr_addr == ADDR_CTRL) && w_strb_r[0];
  wire wr_cause = wr_go && (wr_addr == ADDR_CAUSE) && w_strb_r[0];
  wire wr_hit = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_CAUSE) ||
                (wr_addr == ADDR_STAT) || (wr_addr == ADDR_CORE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (w_hs) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Control and cause registers; a new cause wins over its clear
  wire [3:0] cause_set = {wdt_s, key_ok, pin_ok, state_r == ST_POR};
  wire [3:0] cause_clr = wr_cause ? w_data_r[3:0] : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_sel_r <= KEY_SEL_DEF;
      long_en_r <= LONG_DEF;
      cause_r <= '0;
    end else begin
      if (wr_ctrl) begin
        key_sel_r <= key_sel_t'(w_data_r[CTRL_SEL_LO +: 2]);
        long_en_r <= w_data_r[CTRL_LONG_BIT];
      end
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  // AXI4-Lite read path
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready = !rvalid_r;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
  wire [31:0] rd_ctrl = {29'h0, long_en_r, key_sel_r};
  wire [31:0] rd_cause = {28'h0, cause_r};
  wire [31:0] rd_stat = {24'h0, state_r, filt_busy, osc_s, wdt_s, key_all, pin_s};
  wire [31:0] rd_core = {14'h0, dec_r, irq_r, npp_r, page_r, step_r};
  wire rd_hit = (rd_addr == ADDR_CTRL) || (rd_addr == ADDR_CAUSE) ||
                (rd_addr == ADDR_STAT) || (rd_addr == ADDR_CORE);
  wire [31:0] rd_mux = (rd_addr == ADDR_CTRL) ? rd_ctrl :
                       (rd_addr == ADDR_CAUSE) ? rd_cause :
                       (rd_addr == ADDR_STAT) ? rd_stat :
                       (rd_addr == ADDR_CORE) ? rd_core : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule : initial_reset_controller
`default_nettype wire

// >>> hdl/rst_pkg.sv
package rst_pkg;
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned FILT_MS = 5;
  localparam int unsigned FILT_CYC = FILT_MS * CLK_KHZ;
  localparam int unsigned LONG_MS = 1000;
  localparam int unsigned LONG_CYC = LONG_MS * CLK_KHZ;
  localparam int unsigned STRETCH_CYC = 4;
  localparam int unsigned SW = 3;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CAUSE = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_CORE = 12'h00c;

  localparam int unsigned CTRL_SEL_LO = 0;
  localparam int unsigned CTRL_LONG_BIT = 2;
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_PIN = 1;
  localparam int unsigned CAUSE_KEY = 2;
  localparam int unsigned CAUSE_WDT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam logic [7:0] STEP_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h1;
  localparam logic [3:0] NEXT_PAGE_RST = 4'h1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [3:0] VEC_PAGE = 4'h1;
  localparam logic [3:0] VEC_FIRST = 4'h1;

  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_01 = 2'h1,
    KEY_012 = 2'h2,
    KEY_0123 = 2'h3
  } key_sel_t;

  typedef enum logic [2:0] {
    ST_POR = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } rst_state_t;
endpackage : rst_pkg

// >>> verif/ext_reset_src.sv
`timescale 1ns/100ps
`default_nettype none
module ext_reset_src (
  // Clock
  input wire logic clk,
  // Pins
  output logic reset_pin,
  output logic [3:0] key_inputs
);
  initial begin
    reset_pin = 1'b0;
    key_inputs = 4'h0;
  end
  task automatic pin(input int n);
    reset_pin <= 1'b1;
    repeat (n) @(posedge clk);
    reset_pin <= 1'b0;
  endtask : pin
  // Keys drop back low so no combo stands between presses
  task automatic keys(input logic [3:0] k, input int n);
    key_inputs <= k;
    repeat (n) @(posedge clk);
    key_inputs <= 4'h0;
  endtask : keys
endmodule : ext_reset_src
`default_nettype wire

// >>> verif/initial_reset_controller_chk.sv
`timescale 1ns/100ps
`default_nettype none
module initial_reset_controller_chk #(
  parameter int unsigned FILT_LEN = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sources
  input wire logic osc_running,
  input wire logic reset_pin,
  input wire logic [3:0] key_inputs,
  input wire logic wdt_runaway,
  input wire logic [3:0] vec_sel,
  // Reset and core state
  input wire logic sys_rst,
  input wire logic cpu_run,
  input wire logic [7:0] program_step_counter,
  input wire logic [3:0] program_page_counter,
  input wire logic [3:0] next_page_pointer,
  input wire logic irq_flag,
  input wire logic dec_flag,
  input wire logic [11:0] fetch_addr,
  input wire logic [11:0] vector_addr
);
  int pin_cnt;
  int idle_cnt;
  logic [2:0] live_cnt;
  // Keys 0 and 1 high may form a combo under any select but KEY_NONE, so never quiet
  wire logic quiet = osc_running && !reset_pin && !wdt_runaway && !(&key_inputs[1:0]);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_cnt <= 0;
      idle_cnt <= 0;
      live_cnt <= 3'h0;
    end else begin
      pin_cnt <= reset_pin ? pin_cnt + 1 : 0;
      idle_cnt <= quiet ? idle_cnt + 1 : 0;
      live_cnt <= (live_cnt == 3'h4) ? live_cnt : live_cnt + 3'h1;
    end
  end
  // Internal reset lags rstn by two flops, so wait before judging
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || live_cnt != 3'h4);
  sequence held_rst;
    sys_rst [*4];
  endsequence
  run_flag_a: assert property (cpu_run != sys_rst)
    else $error("cpu_run is not the inverse of sys_rst");
  core_init_a: assert property (sys_rst [*2] |-> program_step_counter == 8'h00 &&
    program_page_counter == 4'h1 && next_page_pointer == 4'h1 && !irq_flag && !dec_flag)
    else $error("core registers not at reset values");
  fetch_map_a: assert property (fetch_addr == {program_page_counter, program_step_counter})
    else $error("fetch address mismatch");
  vector_map_a: assert property (vector_addr ==
    {8'h10, ($past(vec_sel) == 4'h0) ? 4'h1 : $past(vec_sel)})
    else $error("vector address mismatch");
  osc_hold_a: assert property (!osc_running [*5] |-> sys_rst)
    else $error("reset not held while oscillator stopped");
  pin_hold_a: assert property (pin_cnt == FILT_LEN + 6 |-> sys_rst)
    else $error("long pin request gave no reset");
  idle_rel_a: assert property (idle_cnt == 12 |-> !sys_rst)
    else $error("reset not released when sources idle");
  wdt_rst_a: assert property (wdt_runaway |-> ##[1:4] held_rst)
    else $error("watchdog did not hold reset");
endmodule : initial_reset_controller_chk
bind initial_reset_controller initial_reset_controller_chk #(.FILT_LEN(FILT_LEN)) u_chk (
  .clk, .rstn, .osc_running, .reset_pin, .key_inputs, .wdt_runaway, .vec_sel, .sys_rst,
  .cpu_run, .program_step_counter, .program_page_counter, .next_page_pointer, .irq_flag,
  .dec_flag, .fetch_addr, .vector_addr);
`default_nettype wire

// >>> verif/initial_reset_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module initial_reset_controller_tb;
  import rst_pkg::*;
  localparam int FL = 8;
  localparam int LL = 20;
  logic clk;
  logic rstn = 1'b0;
  logic osc_running = 1'b0;
  logic wdt_runaway = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [21:0] rnd = 22'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata, d;
  logic [1:0] s_axi_rresp, r, s_axi_bresp, b;
  logic reset_pin, sys_rst, cpu_run, irq_flag, dec_flag;
  logic [3:0] key_inputs, program_page_counter, next_page_pointer;
  logic [7:0] program_step_counter;
  logic [11:0] fetch_addr, vector_addr;
  int seed = 85;
  int err_count = 0;
  int num_checks = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) rnd <= 22'($random(seed));
  initial_reset_controller #(.FILT_LEN(FL), .LONG_LEN(LL)) u_initial_reset_controller (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .osc_running, .reset_pin, .key_inputs, .wdt_runaway,
    .core_step_nxt(rnd[7:0]), .core_page_nxt(rnd[11:8]), .core_npp_nxt(rnd[15:12]),
    .core_irq_flag_nxt(rnd[16]), .core_dec_flag_nxt(rnd[17]), .vec_sel(rnd[21:18]),
    .sys_rst, .cpu_run, .program_step_counter, .program_page_counter, .next_page_pointer,
    .irq_flag, .dec_flag, .fetch_addr, .vector_addr);
  ext_reset_src u_ext_reset_src (.clk, .reset_pin, .key_inputs);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wt(input logic v);
    while (sys_rst !== v) @(posedge clk);
  endtask : wt
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Idle edge so a following call never re-raises bready in this step
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Cause bits are sticky, so clear them after each look
  task automatic cause(input logic [3:0] k);
    logic [31:0] v;
    logic [1:0] e;
    rd(ADDR_CAUSE, v, e);
    chk(v[3:0], k);
    chk(e, RESP_OKAY);
    wr(ADDR_CAUSE, 32'hf);
    chk(b, RESP_OKAY);
  endtask : cause
  function automatic logic [3:0] sel_keys(input int s);
    return (s == 0) ? 4'hf : 4'(~(4'he << s));
  endfunction : sel_keys
  task automatic end_sim;
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    cyc(20);
    chk(sys_rst, 1'b1);
    rd(ADDR_CORE, d, r);
    chk(d[17:0], 18'h01100);
    chk(fetch_addr, 12'h100);
    osc_running <= 1'b1;
    wt(1'b0);
    cause(4'h1);
    u_ext_reset_src.pin(FL - 3);
    cyc(12);
    chk(sys_rst, 1'b0);
    u_ext_reset_src.pin(FL + 7);
    chk(sys_rst, 1'b1);
    cyc(12);
    chk(sys_rst, 1'b0);
    cause(4'h2);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 32'(s));
      u_ext_reset_src.keys(sel_keys(s) & 4'he, FL + 7);
      chk(sys_rst, 1'b0);
      cyc(4);
      u_ext_reset_src.keys(sel_keys(s), FL + 7);
      chk(sys_rst, s != 0);
      wt(1'b0);
      cause((s != 0) ? 4'h4 : 4'h0);
    end
    wr(ADDR_CTRL, 32'h7);
    u_ext_reset_src.keys(4'hf, FL + 7);
    chk(sys_rst, 1'b0);
    cyc(4);
    u_ext_reset_src.keys(4'hf, FL + LL + 7);
    chk(sys_rst, 1'b1);
    wt(1'b0);
    cause(4'h4);
    wdt_runaway <= 1'b1;
    cyc(1);
    wdt_runaway <= 1'b0;
    cyc(4);
    chk(sys_rst, 1'b1);
    wt(1'b0);
    cause(4'h8);
    rd(12'h010, d, r);
    chk(r, RESP_DECERR);
    chk(d, 32'h0);
    wr(12'h010, 32'h0);
    chk(b, RESP_DECERR);
    end_sim;
  end
endmodule : initial_reset_controller_tb
`default_nettype wire
